// *** src/vldr_cfg.svh ***
// Register map, field positions, reset values and counts of the
// video line data receiver.
// Assumes inclusion by bare name from the top module.
`ifndef VLDR_CFG_SVH
`define VLDR_CFG_SVH

`define VLDR_ADDR_VSYNC_PRV  8'h24
`define VLDR_ADDR_VBP_LO     8'h25
`define VLDR_ADDR_VBP_HI     8'h26
`define VLDR_ADDR_CTRL       8'h27
`define VLDR_ADDR_WSM_LO     8'h28
`define VLDR_ADDR_WSM_HI     8'h29
`define VLDR_ADDR_WLS_LO     8'h2a
`define VLDR_ADDR_WLS_HI     8'h2b
`define VLDR_ADDR_WDM_LO     8'h2c
`define VLDR_ADDR_WDM_HI     8'h2d
`define VLDR_ADDR_PAY_FIRST  8'h2e
`define VLDR_ADDR_PAY_LAST   8'h36
`define VLDR_ADDR_SHADOW     8'h37
`define VLDR_ADDR_TCFG       8'h39

`define VLDR_BIT_STAT        7
`define VLDR_BIT_WDE         6
`define VLDR_BIT_LIMIT       1
`define VLDR_BIT_BLIRQ       2

`define VLDR_CTRL_RST        8'h00
`define VLDR_TCFG_RST        8'h02
`define VLDR_TCFG_MASK       8'h06

`define VLDR_PULSES          7'h48
`define VLDR_PCNT_MAX        7'h7f
`define VLDR_PAY_BYTES       9
`define VLDR_SR_BITS         72

`endif

// *** src/vldr_pkg.sv ***
// Types shared by the receiver modules.
// Assumes vldr_cfg.svh is on the include path.
package vldr_pkg;
    typedef enum logic [1:0] {
        VLDR_FN_NONE = 2'h0,
        VLDR_FN_DATA = 2'h1,
        VLDR_FN_CLK  = 2'h2,
        VLDR_FN_WIN  = 2'h3
    } vldr_func_e;

    typedef enum logic [3:0] {
        VLDR_FLD_WAIT   = 4'h1,
        VLDR_FLD_SYNC   = 4'h2,
        VLDR_FLD_PORCH  = 4'h4,
        VLDR_FLD_ACTIVE = 4'h8
    } vldr_fld_e;

    typedef logic [7:0] vldr_byte_t;
endpackage : vldr_pkg

// *** src/vldr_sync_if.sv ***
// Synchronised levels and edges passed from the pin synchroniser.
// Assumes both ends run on mclk.
`timescale 1ns/100ps
interface vldr_sync_if #(parameter int W = 6);
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : vldr_sync_if

// *** src/vldr_pin_sync.sv ***
// Two-flop synchroniser with edge detection for the video pins.
// Assumes asynchronous pins; edges come only from the second stage on.
`timescale 1ns/100ps
module vldr_pin_sync #(
    parameter int W = 6
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pins,
    vldr_sync_if.src          sy
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // First stage feeds the second stage only
    assign sy.lvl  = s2_r;
    assign sy.rise = s2_r & ~s3_r;
    assign sy.fall = ~s2_r & s3_r;
endmodule : vldr_pin_sync

// *** src/vldr_top.sv ***
// Video line data receiver: serial block capture, window timing and
// previous-field vertical measurements behind the byte register port.
// Assumes pins are asynchronous; register port and video_present,
// video_detect_reset come from logic on mclk.
//
// Summary of operation
// - Keep previous field vertical sync width, 8 bits, in lines.
// - Keep previous field vertical back porch, 11 bits, in lines.
// - Without video, back porch plus sync spans the whole field.
// - Detect reset clears the previous field values to zero.
// - Two select bits per colour: unused, data, clock, window.
// - Window detect enable resets low and holds until host sets it.
// - First accepted 72-pulse line latches window timing values.
// - Exactly 72 valid pulses at hsync load payload, set flag.
// - Payload loads only with flag low, else shift data dropped.
// - Reading the shadow control register clears the flag.
// - Once flag clears, next valid block may update payload.
// - With flag low, time hsync start to window start, 11 bits.
// - Window start reads zero when no video is present.
// - Shadow read zeroes window values; resume at next vsync.
// - Host reads all six window bytes before clearing flag.
// - With flag low, time hsync width in blanking, 10 bits.
// - Limit bit confines accepted runs to vertical blanking.
// - Measure window pulse length on the window line, 11 bits.
// - Blank/irq select makes the output follow the capture flag.
`timescale 1ns/100ps
`include "vldr_cfg.svh"
module vldr_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        line_red,
    input  wire logic        line_green,
    input  wire logic        line_blue,
    input  wire logic        hsync,
    input  wire logic        vsync,
    input  wire logic        vblank,
    input  wire logic        video_present,
    input  wire logic        video_detect_reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire vldr_pkg::vldr_byte_t reg_wdata,
    output vldr_pkg::vldr_byte_t      reg_rdata,
    output logic             blank_irq
);
    import vldr_pkg::*;

    vldr_sync_if #(.W(6)) sy ();

    vldr_pin_sync #(.W(6)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .pins ({vblank, vsync, hsync, line_green, line_blue, line_red}),
        .sy   (sy)
    );

    // Channel i owns select bits [2i+1:2i]
    function automatic logic pick(input logic [5:0] ctl,
                                  input logic [2:0] v,
                                  input vldr_func_e fn);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (ctl[2*i +: 2] == fn) r = r | v[i];
        end
        return r;
    endfunction : pick

    vldr_byte_t  ctrl_r, ctrl_nxt, tcfg_r, tcfg_nxt;
    vldr_byte_t  rdata_r, rdata_nxt;
    logic        blirq_r, blirq_nxt;
    vldr_byte_t  pay_r   [0:`VLDR_PAY_BYTES-1];
    vldr_byte_t  pay_nxt [0:`VLDR_PAY_BYTES-1];
    logic [71:0] sr_r, sr_nxt;
    logic [6:0]  pcnt_r, pcnt_nxt;
    logic        runok_r, runok_nxt;
    logic [10:0] lcnt_r, lcnt_nxt, wst_t_r, wst_t_nxt, wlen_t_r, wlen_t_nxt;
    logic [9:0]  hsw_t_r, hsw_t_nxt, wls_r, wls_nxt;
    logic [10:0] wsm_r, wsm_nxt, wdm_r, wdm_nxt;
    logic        meas_en_r, meas_en_nxt;
    vldr_fld_e   fld_r, fld_nxt;
    logic [7:0]  vs_cnt_r, vs_cnt_nxt, vs_cur_r, vs_cur_nxt;
    logic [7:0]  vs_prv_r, vs_prv_nxt;
    logic [10:0] bp_cnt_r, bp_cnt_nxt, bp_cur_r, bp_cur_nxt;
    logic [10:0] bp_prv_r, bp_prv_nxt;

    logic hs_rise, hs_fall, vs_rise, vs_fall, vb_lvl, vb_fall;
    logic d_bit, ck_rise, win_rise, win_fall;
    logic accept, shadow_rd, stat_clr;

    assign hs_rise  = sy.rise[3];
    assign hs_fall  = sy.fall[3];
    assign vs_rise  = sy.rise[4];
    assign vs_fall  = sy.fall[4];
    assign vb_lvl   = sy.lvl[5];
    assign vb_fall  = sy.fall[5];
    assign d_bit    = pick(ctrl_r[5:0], sy.lvl[2:0], VLDR_FN_DATA);
    assign ck_rise  = pick(ctrl_r[5:0], sy.rise[2:0], VLDR_FN_CLK);
    assign win_rise = pick(ctrl_r[5:0], sy.rise[2:0], VLDR_FN_WIN);
    assign win_fall = pick(ctrl_r[5:0], sy.fall[2:0], VLDR_FN_WIN);

    assign shadow_rd = reg_rd && reg_addr == `VLDR_ADDR_SHADOW;
    assign stat_clr  = shadow_rd || (reg_wr && reg_addr == `VLDR_ADDR_CTRL
                       && !reg_wdata[`VLDR_BIT_STAT]);
    // Exactly 72 pulses, all inside the valid period, flag still low
    assign accept = hs_rise && pcnt_r == `VLDR_PULSES && runok_r
                    && !ctrl_r[`VLDR_BIT_STAT];

    // Receive shifter
    always_comb begin
        sr_nxt    = sr_r;
        pcnt_nxt  = pcnt_r;
        runok_nxt = runok_r;
        if (hs_rise) begin
            sr_nxt    = '0;
            pcnt_nxt  = '0;
            runok_nxt = 1'b1;
        end else if (ck_rise) begin
            sr_nxt = {d_bit, sr_r[71:1]};
            if (pcnt_r != `VLDR_PCNT_MAX) pcnt_nxt = pcnt_r + 7'h01;
            if (tcfg_r[`VLDR_BIT_LIMIT] && !vb_lvl) runok_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sr_r    <= '0;
            pcnt_r  <= '0;
            runok_r <= 1'b0;
        end else begin
            sr_r    <= sr_nxt;
            pcnt_r  <= pcnt_nxt;
            runok_r <= runok_nxt;
        end
    end

    // Window timing; line counter saturates on missing hsync
    always_comb begin
        lcnt_nxt    = (lcnt_r == 11'h7ff) ? lcnt_r : lcnt_r + 11'h001;
        wst_t_nxt   = wst_t_r;
        wlen_t_nxt  = wlen_t_r;
        hsw_t_nxt   = hsw_t_r;
        wsm_nxt     = wsm_r;
        wls_nxt     = wls_r;
        wdm_nxt     = wdm_r;
        meas_en_nxt = meas_en_r;
        if (hs_rise) begin
            lcnt_nxt   = '0;
            wst_t_nxt  = '0;
            wlen_t_nxt = '0;
        end
        if (win_rise) wst_t_nxt = lcnt_r + 11'h001;
        if (win_fall) wlen_t_nxt = lcnt_r + 11'h001 - wst_t_r;
        if (hs_fall && vb_lvl) hsw_t_nxt = lcnt_r[9:0] + 10'h001;
        if (shadow_rd) begin
            wsm_nxt     = '0;
            wls_nxt     = '0;
            wdm_nxt     = '0;
            meas_en_nxt = 1'b0;
        end
        if (vs_rise) meas_en_nxt = 1'b1;
        // Timing is frozen once the flag is set, so reads stay coherent
        if (accept && meas_en_r && ctrl_r[`VLDR_BIT_WDE]) begin
            wsm_nxt = wst_t_r;
            wls_nxt = hsw_t_r;
            wdm_nxt = wlen_t_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lcnt_r    <= '0;
            wst_t_r   <= '0;
            wlen_t_r  <= '0;
            hsw_t_r   <= '0;
            wsm_r     <= '0;
            wls_r     <= '0;
            wdm_r     <= '0;
            meas_en_r <= 1'b0;
        end else begin
            lcnt_r    <= lcnt_nxt;
            wst_t_r   <= wst_t_nxt;
            wlen_t_r  <= wlen_t_nxt;
            hsw_t_r   <= hsw_t_nxt;
            wsm_r     <= wsm_nxt;
            wls_r     <= wls_nxt;
            wdm_r     <= wdm_nxt;
            meas_en_r <= meas_en_nxt;
        end
    end

    // Field timing in line periods
    always_comb begin
        fld_nxt    = fld_r;
        vs_cnt_nxt = vs_cnt_r;
        vs_cur_nxt = vs_cur_r;
        vs_prv_nxt = vs_prv_r;
        bp_cnt_nxt = bp_cnt_r;
        bp_cur_nxt = bp_cur_r;
        bp_prv_nxt = bp_prv_r;
        unique case (fld_r)
            VLDR_FLD_WAIT: begin
                if (vs_rise) fld_nxt = VLDR_FLD_SYNC;
                vs_cnt_nxt = '0;
            end
            VLDR_FLD_SYNC: begin
                if (hs_rise && vs_cnt_r != 8'hff)
                    vs_cnt_nxt = vs_cnt_r + 8'h01;
                if (vs_fall) begin
                    fld_nxt    = VLDR_FLD_PORCH;
                    vs_cur_nxt = vs_cnt_r;
                    bp_cnt_nxt = '0;
                end
            end
            VLDR_FLD_PORCH: begin
                if (hs_rise && bp_cnt_r != 11'h7ff)
                    bp_cnt_nxt = bp_cnt_r + 11'h001;
                // Without video the porch runs on to the next vsync
                if (vs_rise) begin
                    fld_nxt    = VLDR_FLD_SYNC;
                    vs_prv_nxt = vs_cur_r;
                    bp_prv_nxt = bp_cnt_r;
                    vs_cnt_nxt = '0;
                end else if (video_present && vb_fall) begin
                    fld_nxt    = VLDR_FLD_ACTIVE;
                    bp_cur_nxt = bp_cnt_r;
                end
            end
            VLDR_FLD_ACTIVE: begin
                if (vs_rise) begin
                    fld_nxt    = VLDR_FLD_SYNC;
                    vs_prv_nxt = vs_cur_r;
                    bp_prv_nxt = bp_cur_r;
                    vs_cnt_nxt = '0;
                end
            end
        endcase
        if (video_detect_reset) begin
            fld_nxt    = VLDR_FLD_WAIT;
            vs_prv_nxt = '0;
            bp_prv_nxt = '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fld_r    <= VLDR_FLD_WAIT;
            vs_cnt_r <= '0;
            vs_cur_r <= '0;
            vs_prv_r <= '0;
            bp_cnt_r <= '0;
            bp_cur_r <= '0;
            bp_prv_r <= '0;
        end else begin
            fld_r    <= fld_nxt;
            vs_cnt_r <= vs_cnt_nxt;
            vs_cur_r <= vs_cur_nxt;
            vs_prv_r <= vs_prv_nxt;
            bp_cnt_r <= bp_cnt_nxt;
            bp_cur_r <= bp_cur_nxt;
            bp_prv_r <= bp_prv_nxt;
        end
    end

    // Host registers; a capture in the clearing cycle wins
    always_comb begin
        ctrl_nxt  = ctrl_r;
        tcfg_nxt  = tcfg_r;
        pay_nxt   = pay_r;
        rdata_nxt = rdata_r;
        if (reg_wr && reg_addr == `VLDR_ADDR_CTRL)
            ctrl_nxt[6:0] = reg_wdata[6:0];
        if (reg_wr && reg_addr == `VLDR_ADDR_TCFG)
            tcfg_nxt = reg_wdata & `VLDR_TCFG_MASK;
        if (stat_clr) ctrl_nxt[`VLDR_BIT_STAT] = 1'b0;
        if (accept) begin
            ctrl_nxt[`VLDR_BIT_STAT] = 1'b1;
            for (int b = 0; b < `VLDR_PAY_BYTES; b++)
                pay_nxt[b] = sr_r[8*b +: 8];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `VLDR_ADDR_VSYNC_PRV: rdata_nxt = vs_prv_r;
                `VLDR_ADDR_VBP_LO:    rdata_nxt = bp_prv_r[7:0];
                `VLDR_ADDR_VBP_HI:    rdata_nxt = {5'h00, bp_prv_r[10:8]};
                `VLDR_ADDR_CTRL,
                `VLDR_ADDR_SHADOW:    rdata_nxt = ctrl_r;
                `VLDR_ADDR_WSM_LO:
                    rdata_nxt = video_present ? wsm_r[7:0] : 8'h00;
                `VLDR_ADDR_WSM_HI:
                    rdata_nxt = video_present ? {5'h00, wsm_r[10:8]} : 8'h00;
                `VLDR_ADDR_WLS_LO:    rdata_nxt = wls_r[7:0];
                `VLDR_ADDR_WLS_HI:    rdata_nxt = {6'h00, wls_r[9:8]};
                `VLDR_ADDR_WDM_LO:    rdata_nxt = wdm_r[7:0];
                `VLDR_ADDR_WDM_HI:    rdata_nxt = {5'h00, wdm_r[10:8]};
                `VLDR_ADDR_TCFG:      rdata_nxt = tcfg_r;
                default: begin
                    if (reg_addr >= `VLDR_ADDR_PAY_FIRST
                        && reg_addr <= `VLDR_ADDR_PAY_LAST)
                        rdata_nxt = pay_r[4'(reg_addr - `VLDR_ADDR_PAY_FIRST)];
                    else
                        rdata_nxt = 8'h00;
                end
            endcase
        end
        blirq_nxt = tcfg_nxt[`VLDR_BIT_BLIRQ] ?
                    ctrl_nxt[`VLDR_BIT_STAT] : vb_lvl;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r  <= `VLDR_CTRL_RST;
            tcfg_r  <= `VLDR_TCFG_RST;
            rdata_r <= '0;
            blirq_r <= 1'b0;
            for (int b = 0; b < `VLDR_PAY_BYTES; b++) pay_r[b] <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            tcfg_r  <= tcfg_nxt;
            rdata_r <= rdata_nxt;
            blirq_r <= blirq_nxt;
            pay_r   <= pay_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign blank_irq = blirq_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_prv_clear;
        video_detect_reset |=> vs_prv_r == 8'h00 && bp_prv_r == 11'h000;
    endproperty
    a_prv_clear: assert property (p_prv_clear)
        else $error("previous field values not cleared");

    property p_stat_set;
        accept |=> ctrl_r[`VLDR_BIT_STAT] && pay_r[0] == $past(sr_r[7:0]);
    endproperty
    a_stat_set: assert property (p_stat_set)
        else $error("capture did not load payload and flag");

    property p_hold;
        ctrl_r[`VLDR_BIT_STAT] |=> pay_r[8] == $past(pay_r[8]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("payload changed while flag set");

    property p_shadow_clr;
        shadow_rd && !accept |=> !ctrl_r[`VLDR_BIT_STAT];
    endproperty
    a_shadow_clr: assert property (p_shadow_clr)
        else $error("shadow read left flag set");

    property p_wsm_zero;
        reg_rd && reg_addr == `VLDR_ADDR_WSM_LO && !video_present
            |=> reg_rdata == 8'h00;
    endproperty
    a_wsm_zero: assert property (p_wsm_zero)
        else $error("window start nonzero without video");

    property p_win_clear;
        shadow_rd && !accept ##1 !vs_rise [*2] |=> !meas_en_r && wsm_r == '0;
    endproperty
    a_win_clear: assert property (p_win_clear)
        else $error("window measure resumed before vsync");

    property p_limit;
        ck_rise && !hs_rise && tcfg_r[`VLDR_BIT_LIMIT] && !vb_lvl
            ##1 !hs_rise [*3] |=> !accept;
    endproperty
    a_limit: assert property (p_limit)
        else $error("run outside blanking accepted");

    property p_irq;
        tcfg_r[`VLDR_BIT_BLIRQ] |-> blank_irq == ctrl_r[`VLDR_BIT_STAT];
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output not following flag");

    property p_shift;
        ck_rise && !hs_rise |=> sr_r[71] == $past(d_bit)
            && sr_r[70:0] == $past(sr_r[71:1]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("data bit not shifted on clock pulse");
endmodule : vldr_top

// *** tb/vldr_src_model.sv ***
// Video source model: sync, blanking and serial data blocks on three lines.
// Assumes the bench calls its tasks just after an mclk edge.
`timescale 1ns/100ps
module vldr_src_model (
    input  wire logic mclk,
    output logic      hsync,
    output logic      vsync,
    output logic      vblank,
    output logic      dat_ln,
    output logic      clk_ln,
    output logic      win_ln
);
    initial begin
        {hsync, vsync, vblank, dat_ln, clk_ln, win_ln} = 6'h00;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt

    // One plain line: 10-cycle sync inside a 40-cycle line
    task automatic hs();
        hsync <= 1'b1;
        wt(10);
        hsync <= 1'b0;
        wt(30);
    endtask : hs

    // Link clock of 8 mclk cycles; data settles half a period before rise
    task automatic blk(input int n, input logic [71:0] d, input logic vb);
        vblank <= vb;
        hsync  <= 1'b1;
        wt(10);
        hsync  <= 1'b0;
        wt(10);
        win_ln <= 1'b1;
        for (int k = 0; k < n; k++) begin
            dat_ln <= d[k % 72];
            wt(4);
            clk_ln <= 1'b1;
            wt(4);
            clk_ln <= 1'b0;
        end
        win_ln <= 1'b0;
        // Released data line must not keep showing the last bit
        dat_ln <= ~dat_ln;
        wt(20);
    endtask : blk

    // Sync edges kept apart so each hsync rise falls in one region only
    task automatic field(input int vsl, input int bpl, input int act);
        vblank <= 1'b1;
        vsync  <= 1'b1;
        wt(2);
        repeat (vsl) hs();
        vsync <= 1'b0;
        wt(2);
        repeat (bpl) hs();
        if (act != 0) vblank <= 1'b0;
        wt(2);
        repeat (act) hs();
    endtask : field
endmodule : vldr_src_model

// *** tb/testbench.sv ***
// Self-checking bench for the video line data receiver.
// Assumes vldr_top and the source model; red=data, blue=clock, green=window.
`timescale 1ns/100ps
module testbench;
    import vldr_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic       w;
        vldr_byte_t d;
        vldr_byte_t e;
    } vldr_row_s;
    typedef struct packed {
        int         n;
        logic       vb;
        vldr_byte_t t1;
        logic       f;
    } vldr_blk_s;
    localparam logic [71:0] pay = 72'h5a_c3_96_0f_e1_7b_24_d8_3c;
    logic       mclk;
    logic       rst;
    logic       video_present;
    logic       video_detect_reset;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    vldr_byte_t reg_wdata;
    vldr_byte_t reg_rdata;
    vldr_byte_t rd_v;
    vldr_byte_t s;
    vldr_byte_t b;
    logic       hsync;
    logic       vsync;
    logic       vblank;
    logic       dat_ln;
    logic       clk_ln;
    logic       win_ln;
    logic       blank_irq;
    int         bad_count;
    int         total_checks;
    vldr_row_s  rows [8] = '{
        '{8'h39, 1'b0, 8'h00, 8'h02}, '{8'h3a, 1'b1, 8'hff, 8'h00},
        '{8'h25, 1'b1, 8'hff, 8'h00}, '{8'h27, 1'b1, 8'hff, 8'h7f},
        '{8'h27, 1'b1, 8'h00, 8'h00}, '{8'h39, 1'b1, 8'hff, 8'h06},
        '{8'h39, 1'b1, 8'h06, 8'h06}, '{8'h27, 1'b1, 8'h79, 8'h79}};
    vldr_blk_s  blks [4] = '{'{71, 1'b1, 8'h02, 1'b0},
        '{73, 1'b1, 8'h06, 1'b0}, '{72, 1'b0, 8'h06, 1'b0},
        '{72, 1'b0, 8'h04, 1'b1}};

    vldr_top u_dut (.mclk(mclk), .rst(rst), .line_red(dat_ln),
        .line_green(win_ln), .line_blue(clk_ln), .hsync(hsync),
        .vsync(vsync), .vblank(vblank), .video_present(video_present),
        .video_detect_reset(video_detect_reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .blank_irq(blank_irq));
    vldr_src_model u_src (.mclk(mclk), .hsync(hsync), .vsync(vsync),
        .vblank(vblank), .dat_ln(dat_ln), .clk_ln(clk_ln), .win_ln(win_ln));

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task automatic chk(input string nm, input vldr_byte_t seen,
                       input vldr_byte_t exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input vldr_byte_t d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is registered: valid one cycle after the strobe
    task automatic rd(input logic [7:0] a, output vldr_byte_t d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        // Taken one edge later so all stimulus stays on the rising edge
        @(posedge mclk);
        d = reg_rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input vldr_byte_t e);
        rd(a, rd_v);
        chk($sformatf("reg %h", a), rd_v, e);
    endtask : rchk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        rst = 1'b1;
        video_present = 1'b1;
        video_detect_reset = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        bad_count = 0;
        total_checks = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 8'h24; a <= 8'h37; a++) rchk(a[7:0], 8'h00);
        for (int i = 0; i < 8; i++) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e);
        end
        $display("register table done");
        u_src.field(3, 2, 0);
        u_src.blk(72, pay, 1'b1);
        u_src.hs();
        rchk(8'h27, 8'hf9);
        chk("blank_irq", {7'h00, blank_irq}, 8'h01);
        for (int k = 0; k < 9; k++)
            rchk(8'(8'h2e + k), pay[8*k+:8]);
        rchk(8'h28, 8'h14);
        rchk(8'h29, 8'h00);
        rchk(8'h2a, 8'h0a);
        rchk(8'h2b, 8'h00);
        rchk(8'h2c, 8'h40);
        rchk(8'h2d, 8'h02);
        video_present <= 1'b0;
        rchk(8'h28, 8'h00);
        video_present <= 1'b1;
        u_src.blk(72, ~pay, 1'b1);
        u_src.hs();
        rchk(8'h2e, pay[7:0]);
        rchk(8'h37, 8'hf9);
        rchk(8'h27, 8'h79);
        chk("blank_irq", {7'h00, blank_irq}, 8'h00);
        rchk(8'h28, 8'h00);
        u_src.blk(72, ~pay, 1'b1);
        u_src.hs();
        rchk(8'h2e, ~pay[7:0]);
        rchk(8'h2c, 8'h00);
        rd(8'h37, rd_v);
        $display("capture done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h39, blks[i].t1);
            u_src.blk(blks[i].n, pay, blks[i].vb);
            u_src.hs();
            rchk(8'h27, {blks[i].f, 7'h79});
            // Blanking mode follows vblank, interrupt mode the flag
            s = {7'h00, blks[i].t1[2] ? blks[i].f : blks[i].vb};
            chk("blank_irq", {7'h00, blank_irq}, s);
            if (blks[i].f) begin
                wr(8'h27, 8'h79);
                rchk(8'h27, 8'h79);
            end
        end
        $display("block acceptance done");
        repeat (3) u_src.field(3, 5, 4);
        rchk(8'h24, 8'h03);
        rchk(8'h25, 8'h05);
        rchk(8'h26, 8'h00);
        @(posedge mclk);
        video_detect_reset <= 1'b1;
        @(posedge mclk);
        video_detect_reset <= 1'b0;
        rchk(8'h24, 8'h00);
        rchk(8'h25, 8'h00);
        video_present <= 1'b0;
        // Several whole fields pass before reading after the detect reset
        repeat (3) u_src.field(3, 5, 4);
        rd(8'h24, s);
        rd(8'h25, b);
        chk("field sum", (s + b == 8'h0b) ? 8'h0c : s + b, 8'h0c);
        $display("field measurement done");
        give_verdict();
    end

    // Whole sequence needs about 8000 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
endmodule : testbench
